// ===== hw/scan_controller.sv
// Emulator end: makes the link clock and runs scan commands
`include "jtag_emu_consts.svh"

module scan_controller #(
  parameter int HALF_DIV = `TCK_HALF_DIV
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  jtag_emu_if.host         link,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_ir_in,
  input  wire logic [5:0]  cmd_len_in,
  input  wire logic [31:0] cmd_data_in,
  output logic             cmd_ready_out,
  output logic             rsp_valid_out,
  output logic             rsp_err_out,
  output logic [31:0]      rsp_data_out,
  input  wire logic [1:0]  emu_pull_in,
  output logic [1:0]       emu_level_out
);
  import tap_pkg::*;

  generate
    if (HALF_DIV < `TCK_HALF_MIN) begin : g_bad_div
      $error("HALF_DIV too small for the scan output synchroniser");
    end
  endgenerate

  host_state_t state_q;
  logic [7:0]  ph_q;
  logic        tck_q;
  logic        tms_q;
  logic        tdi_q;
  logic        trst_n_q;
  logic [6:0]  step_q;
  logic [6:0]  pre_q;
  logic [6:0]  len_q;
  logic [31:0] data_q;
  logic [31:0] rsp_q;
  logic        rsp_v_q;
  logic        err_q;
  logic        tdo_s1_q;
  logic        tdo_s2_q;
  logic [1:0]  lvl_s1_q;
  logic [1:0]  lvl_s2_q;
  logic [1:0]  emu_oe_n_q;
  logic        ready_q;
  logic        tick;
  logic        rise;
  logic        fall;
  logic [6:0]  shift_end;
  logic [6:0]  bit_idx;
  logic [6:0]  pbit;
  logic [6:0]  eff_len;
  logic        bad_cmd;

  assign tick      = (ph_q == 8'(HALF_DIV - 1));
  assign rise      = tick && !tck_q;
  assign fall      = tick && tck_q;
  assign shift_end = pre_q + len_q;
  assign pbit      = step_q - 7'h01;
  assign bit_idx   = step_q - pre_q;
  assign eff_len   = cmd_ir_in ? 7'(`IR_WIDTH) : {1'b0, cmd_len_in};
  // Refuse empty scans, scans longer than SCAN_MAX and reserved instruction codes
  assign bad_cmd = (eff_len == 7'h00) || (eff_len > 7'(`SCAN_MAX)) ||
                   (cmd_ir_in && is_private(cmd_data_in[7:0]));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_q  <= 8'h00;
      tck_q <= 1'b0;
    end else begin
      ph_q <= tick ? 8'h00 : ph_q + 8'h01;
      if (tick) begin
        tck_q <= !tck_q;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tdo_s1_q <= 1'b1;
      tdo_s2_q <= 1'b1;
      lvl_s1_q <= 2'h3;
      lvl_s2_q <= 2'h3;
    end else begin
      tdo_s1_q <= link.tdo_line;
      tdo_s2_q <= tdo_s1_q;
      lvl_s1_q <= link.emu_line;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // Conforming emulator may also pull the shared lines low
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      emu_oe_n_q <= 2'h3;
    end else begin
      emu_oe_n_q <= ~emu_pull_in;
    end
  end

  // Ready is registered and drops in the cycle that takes a command,
  // so a request held one cycle too long is never taken twice.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else begin
      if (state_q == hs_idle) begin
        ready_q <= !(cmd_valid_in && ready_q);
      end else begin
        ready_q <= (state_q == hs_reset) && fall &&
                   (step_q == 7'(`RESET_TCKS));
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q  <= hs_reset;
      step_q   <= 7'h00;
      pre_q    <= 7'h00;
      len_q    <= 7'h00;
      data_q   <= 32'h0;
      rsp_q    <= 32'h0;
      rsp_v_q  <= 1'b0;
      err_q    <= 1'b0;
      tms_q    <= 1'b1;
      tdi_q    <= 1'b0;
      trst_n_q <= 1'b0;
    end else begin
      rsp_v_q <= 1'b0;
      case (state_q)
        hs_reset: begin
          if (fall) begin
            step_q <= step_q + 7'h01;
            if (step_q == 7'(`RESET_TCKS)) begin
              trst_n_q <= 1'b1;
              tms_q    <= 1'b0;
              step_q   <= 7'h00;
              state_q  <= hs_idle;
            end
          end
        end
        hs_idle: begin
          if (cmd_valid_in && ready_q && bad_cmd) begin
            err_q   <= 1'b1;
            rsp_q   <= 32'h0;
            rsp_v_q <= 1'b1;
          end else if (cmd_valid_in && ready_q) begin
            err_q   <= 1'b0;
            rsp_q   <= 32'h0;
            len_q   <= eff_len;
            pre_q   <= cmd_ir_in ? 7'(`PRE_IR_STEPS) : 7'(`PRE_DR_STEPS);
            data_q  <= cmd_data_in;
            step_q  <= 7'h00;
            state_q <= hs_shift;
          end
        end
        hs_shift: begin
          if (fall) begin
            step_q <= step_q + 7'h01;
            tdi_q  <= (step_q >= pre_q) && (step_q < shift_end) &&
                      data_q[bit_idx[4:0]];
            if (step_q < pre_q) begin
              tms_q <= (step_q == 7'h00) ||
                       ((pre_q == 7'(`PRE_IR_STEPS)) &&
                        (step_q == 7'h01));
            end else begin
              tms_q <= (step_q == shift_end - 7'h01) ||
                       (step_q == shift_end);
            end
          end else if (rise && (step_q != 7'h00)) begin
            if ((pbit >= pre_q) && (pbit < shift_end)) begin
              rsp_q[5'(pbit - pre_q)] <= tdo_s2_q;
            end
            if (step_q == shift_end + 7'(`POST_STEPS)) begin
              state_q <= hs_done;
            end
          end
        end
        hs_done: begin
          rsp_v_q <= 1'b1;
          state_q <= hs_idle;
        end
        default: state_q <= hs_reset;
      endcase
    end
  end

  assign link.tck           = tck_q;
  assign link.tms           = tms_q;
  assign link.tdi           = tdi_q;
  assign link.trst_n        = trst_n_q;
  assign link.host_emu_o    = 2'h0;
  assign link.host_emu_oe_n = emu_oe_n_q;

  assign cmd_ready_out = ready_q;
  assign rsp_valid_out = rsp_v_q;
  assign rsp_err_out   = err_q;
  assign rsp_data_out  = rsp_q;
  assign emu_level_out = lvl_s2_q;

endmodule

// ===== include/jtag_emu_consts.svh
// Constants shared by both ends of the emulation scan port
`ifndef JTAG_EMU_CONSTS_SVH
`define JTAG_EMU_CONSTS_SVH

`define IR_WIDTH        8
`define IR_CAPTURE      8'h01
`define OP_EXTEST       8'h00
`define OP_SAMPLE       8'h02
`define OP_HIGHZ        8'h06
`define OP_BYPASS       8'hFF
`define OP_PRIV_FIRST   8'h03
`define OP_PRIV_LO      8'h20
`define OP_PRIV_HI      8'h29
`define EMU_LINES       2
`define TCK_HALF_DIV    4
`define TCK_HALF_MIN    3
`define RESET_TCKS      6
`define PRE_DR_STEPS    3
`define PRE_IR_STEPS    4
`define POST_STEPS      2
`define SCAN_MAX        32

`endif

// ===== include/tap_pkg.sv
// Types and decode functions for the emulation scan port
`include "jtag_emu_consts.svh"

package tap_pkg;

  typedef enum logic [15:0] {
    st_reset   = 16'h0001,
    st_idle    = 16'h0002,
    st_sel_dr  = 16'h0004,
    st_cap_dr  = 16'h0008,
    st_sh_dr   = 16'h0010,
    st_ex1_dr  = 16'h0020,
    st_pau_dr  = 16'h0040,
    st_ex2_dr  = 16'h0080,
    st_upd_dr  = 16'h0100,
    st_sel_ir  = 16'h0200,
    st_cap_ir  = 16'h0400,
    st_sh_ir   = 16'h0800,
    st_ex1_ir  = 16'h1000,
    st_pau_ir  = 16'h2000,
    st_ex2_ir  = 16'h4000,
    st_upd_ir  = 16'h8000
  } tap_state_t;

  typedef enum logic [3:0] {
    hs_reset = 4'h1,
    hs_idle  = 4'h2,
    hs_shift = 4'h4,
    hs_done  = 4'h8
  } host_state_t;

  function automatic logic is_private(input logic [7:0] op);
    return (op == `OP_PRIV_FIRST) ||
           ((op >= `OP_PRIV_LO) && (op <= `OP_PRIV_HI));
  endfunction

  // The dummy cell stands in for the absent boundary register
  function automatic logic selects_dummy(input logic [7:0] op);
    return (op == `OP_EXTEST) || (op == `OP_SAMPLE) ||
           (op == `OP_HIGHZ);
  endfunction

endpackage

// ===== include/jtag_emu_if.sv
// Scan link and shared emulation control lines between the two ends
interface jtag_emu_if;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       trst_n;
  logic       tdo;
  logic       tdo_oe_n;
  logic       tdo_line;
  logic [1:0] dev_emu_o;
  logic [1:0] dev_emu_oe_n;
  logic [1:0] host_emu_o;
  logic [1:0] host_emu_oe_n;
  logic [1:0] emu_line;

  // Undriven scan output floats high; shared lines are pulled up
  assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
  assign emu_line = (dev_emu_oe_n | dev_emu_o) &
                    (host_emu_oe_n | host_emu_o);

  modport device (
    input  tck, tms, tdi, trst_n, emu_line,
    output tdo, tdo_oe_n, dev_emu_o, dev_emu_oe_n
  );

  modport host (
    input  tdo_line, emu_line,
    output tck, tms, tdi, trst_n, host_emu_o, host_emu_oe_n
  );
endinterface

// ===== hw/tap_device.sv
// Device end of the emulation scan port, clocked by the link clock
`include "jtag_emu_consts.svh"

module tap_device #(
  parameter int IR_W = `IR_WIDTH
) (
  jtag_emu_if.device        link,
  input  wire logic [1:0]   emu_pull_in,
  output logic [1:0]        emu_level_out,
  output logic [IR_W-1:0]   instr_out,
  output logic              dummy_out,
  output logic              private_out
);
  import tap_pkg::*;

  generate
    if (IR_W != `IR_WIDTH) begin : g_bad_width
      $error("Instruction register width must be eight");
    end
  endgenerate

  tap_state_t      state_q;
  tap_state_t      state_d;
  logic [IR_W-1:0] ir_sr_q;
  logic [IR_W-1:0] ir_q;
  logic            bypass_q;
  logic            dummy_q;
  logic            dummy_upd_q;
  logic            private_q;
  logic            tdo_q;
  logic            tdo_oe_n_q;
  logic [1:0]      pull_s1_q;
  logic [1:0]      pull_s2_q;
  logic [1:0]      line_s1_q;
  logic [1:0]      line_s2_q;
  logic [1:0]      emu_oe_n_q;
  logic            use_dummy;

  // Unlisted and private codes fall back on the bypass bit
  assign use_dummy = selects_dummy(ir_q);

  // State machine follows the standard sixteen-state diagram
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_reset:  state_d = link.tms ? st_reset  : st_idle;
      st_idle:   state_d = link.tms ? st_sel_dr : st_idle;
      st_sel_dr: state_d = link.tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: state_d = link.tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr:  state_d = link.tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: state_d = link.tms ? st_upd_dr : st_pau_dr;
      st_pau_dr: state_d = link.tms ? st_ex2_dr : st_pau_dr;
      st_ex2_dr: state_d = link.tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: state_d = link.tms ? st_sel_dr : st_idle;
      st_sel_ir: state_d = link.tms ? st_reset  : st_cap_ir;
      st_cap_ir: state_d = link.tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir:  state_d = link.tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: state_d = link.tms ? st_upd_ir : st_pau_ir;
      st_pau_ir: state_d = link.tms ? st_ex2_ir : st_pau_ir;
      st_ex2_ir: state_d = link.tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: state_d = link.tms ? st_sel_dr : st_idle;
      default:   state_d = st_reset;
    endcase
  end

  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      state_q <= st_reset;
    end else begin
      state_q <= state_d;
    end
  end

  // Instruction shift stage: fixed capture pattern, eight bits long
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_sr_q <= `IR_CAPTURE;
    end else if (state_q == st_cap_ir) begin
      ir_sr_q <= `IR_CAPTURE;
    end else if (state_q == st_sh_ir) begin
      ir_sr_q <= {link.tdi, ir_sr_q[IR_W-1:1]};
    end
  end

  // Held instruction; reset state selects bypass
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      ir_q <= `OP_BYPASS;
    end else if (state_q == st_reset) begin
      ir_q <= `OP_BYPASS;
    end else if (state_q == st_upd_ir) begin
      ir_q <= ir_sr_q;
    end
  end

  // Private codes are flagged only; the hidden logic is not here
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      private_q <= 1'b0;
    end else begin
      private_q <= is_private(ir_q);
    end
  end

  // One-bit bypass register, captures zero
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      bypass_q <= 1'b0;
    end else if (!use_dummy) begin
      if (state_q == st_cap_dr) begin
        bypass_q <= 1'b0;
      end else if (state_q == st_sh_dr) begin
        bypass_q <= link.tdi;
      end
    end
  end

  // The dummy cell has no pin behind it, so capture keeps its value
  // and a loopback pattern survives the round trip.
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      dummy_q <= 1'b0;
    end else if (use_dummy && (state_q == st_sh_dr)) begin
      dummy_q <= link.tdi;
    end
  end

  // Shift stage and update latch of the dummy cell are all that extest,
  // sample and high-impedance ever change.
  always_ff @(posedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      dummy_upd_q <= 1'b0;
    end else if (use_dummy && (state_q == st_upd_dr)) begin
      dummy_upd_q <= dummy_q;
    end
  end

  // Scan output changes on the falling edge, per the usual timing
  always_ff @(negedge link.tck or negedge link.trst_n) begin
    if (!link.trst_n) begin
      tdo_q      <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_oe_n_q <= !((state_q == st_sh_ir) || (state_q == st_sh_dr));
      if (state_q == st_sh_ir) begin
        tdo_q <= ir_sr_q[0];
      end else if (use_dummy) begin
        tdo_q <= dummy_q;
      end else begin
        tdo_q <= bypass_q;
      end
    end
  end

  // Emulation control lines: requests and levels come from other
  // domains and pass two stages first. Sensing relies on a running
  // link clock; with the clock stopped the levels freeze.
  genvar k;
  generate
    for (k = 0; k < `EMU_LINES; k++) begin : g_emu
      always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
          pull_s1_q[k] <= 1'b0;
          pull_s2_q[k] <= 1'b0;
        end else begin
          pull_s1_q[k] <= emu_pull_in[k];
          pull_s2_q[k] <= pull_s1_q[k];
        end
      end

      always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
          line_s1_q[k] <= 1'b1;
          line_s2_q[k] <= 1'b1;
        end else begin
          line_s1_q[k] <= link.emu_line[k];
          line_s2_q[k] <= line_s1_q[k];
        end
      end

      always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
          emu_oe_n_q[k] <= 1'b1;
        end else begin
          emu_oe_n_q[k] <= !pull_s2_q[k];
        end
      end
    end
  endgenerate

  // Open collector: the driven value is always low
  assign link.dev_emu_o    = 2'h0;
  assign link.dev_emu_oe_n = emu_oe_n_q;
  assign link.tdo          = tdo_q;
  assign link.tdo_oe_n     = tdo_oe_n_q;

  assign emu_level_out = line_s2_q;
  assign instr_out     = ir_q;
  assign dummy_out     = dummy_upd_q;
  assign private_out   = private_q;

endmodule

// ===== testbench/jtag_emu_checker.sv
// Assertions on the scan link joining the controller and the device
module jtag_emu_checker (
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       trst_n,
  input wire logic       tdo,
  input wire logic       tdo_oe_n,
  input wire logic [1:0] dev_emu_o,
  input wire logic [1:0] dev_emu_oe_n,
  input wire logic [1:0] host_emu_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge tck);
  endclocking
  default disable iff (!trst_n);

  // A released scan output on the first high step tells a fresh entry
  // apart from the tail of a shift that just ended
  sequence s_ir_entry;
    !tms ##1 (tms && tdo_oe_n) ##1 tms ##1 !tms ##1 !tms;
  endsequence

  sequence s_dr_entry;
    !tms ##1 (tms && tdo_oe_n) ##1 !tms ##1 !tms;
  endsequence

  sequence s_ir_tail;
    !tms [*7] ##1 tms ##1 tms ##1 !tms;
  endsequence

  a_emu_open_coll: assert property (
    dev_emu_o == 2'b00 && host_emu_o == 2'b00)
    else $error("emulation line driven high");
  a_ir_capture: assert property (
    s_ir_entry |=> tdo ##1 !tdo [*7])
    else $error("instruction capture pattern wrong");
  a_ir_length: assert property (
    s_ir_entry |=> !tdo_oe_n [*8] ##1 tdo_oe_n)
    else $error("instruction shift not eight bits");
  a_ir_order: assert property (
    s_ir_entry |=> s_ir_tail)
    else $error("instruction scan sequence wrong");
  a_dr_loop: assert property (
    s_dr_entry |=> !tdo_oe_n until_with tms)
    else $error("scan output released inside data shift");
  a_dr_bound: assert property (
    s_dr_entry |-> ##[1:32] tms)
    else $error("data shift longer than allowed");
  a_shift_exit: assert property (
    !tdo_oe_n && tms |=> tdo_oe_n)
    else $error("scan output held after leaving shift");
  a_reset_quiet: assert property (
    $rose(trst_n) |-> tdo_oe_n && dev_emu_oe_n == 2'b11)
    else $error("outputs active at end of link reset");
endmodule

// ===== testbench/tb.sv
// Self-checking bench: controller and device joined over the scan link
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, rst_in, cmd_valid, cmd_ir, cmd_ready;
  logic        rsp_valid, rsp_err, dummy, priv, b_priv, prev;
  logic [5:0]  cmd_len;
  logic [31:0] cmd_data, rsp_data;
  logic [1:0]  dev_pull, host_pull, dev_lvl, host_lvl;
  logic [7:0]  instr, b_instr, tdo_cap;
  logic [7:0]  codes [4] = '{8'h00, 8'h02, 8'h06, 8'hFF};
  logic [33:0] exp_q [$];
  logic [33:0] e;
  int          err_count = 0;
  int          total_checks = 0;
  localparam logic [7:0] bad_code = 8'h25;

  jtag_emu_if link();
  jtag_emu_if bad_if();

  scan_controller #(.HALF_DIV(4)) i_scan_controller (
    .mclk_in(mclk), .rst_in(rst_in), .link(link),
    .cmd_valid_in(cmd_valid), .cmd_ir_in(cmd_ir), .cmd_len_in(cmd_len),
    .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_err_out(rsp_err),
    .rsp_data_out(rsp_data), .emu_pull_in(host_pull),
    .emu_level_out(host_lvl));
  tap_device #(.IR_W(8)) i_tap_device (
    .link(link), .emu_pull_in(dev_pull), .emu_level_out(dev_lvl),
    .instr_out(instr), .dummy_out(dummy), .private_out(priv));
  // Second device, bit-banged by the bench to load a forbidden code
  if (1) begin : fault_side
    tap_device #(.IR_W(8)) i_tap_device (
      .link(bad_if), .emu_pull_in(2'b00), .emu_level_out(),
      .instr_out(b_instr), .dummy_out(), .private_out(b_priv));
  end
  jtag_emu_checker i_jtag_emu_checker (
    .tck(link.tck), .tms(link.tms), .trst_n(link.trst_n), .tdo(link.tdo),
    .tdo_oe_n(link.tdo_oe_n), .dev_emu_o(link.dev_emu_o),
    .dev_emu_oe_n(link.dev_emu_oe_n), .host_emu_o(link.host_emu_o));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_ready();
    for (int n = 0; n < 800 && cmd_ready !== 1'b1; n++)
      @(negedge mclk);
    check(cmd_ready, 1'b1);
  endtask

  // Request held until the edge that takes it; a lost answer leaves
  // its note in the queue and is caught at the end
  task automatic do_cmd(input logic ir, input logic [5:0] len,
                        input logic [31:0] d, input logic err,
                        input logic chk, input logic [31:0] exp);
    exp_q.push_back({chk, err, exp});
    @(negedge mclk);
    {cmd_valid, cmd_ir, cmd_len, cmd_data} = {1'b1, ir, len, d};
    wait_ready();
    @(negedge mclk);
    cmd_valid = 1'b0;
    for (int n = 0; n < 800 && rsp_valid !== 1'b1; n++)
      @(negedge mclk);
  endtask

  task automatic load_ir(input logic [7:0] code);
    do_cmd(1'b1, 6'h08, {24'h0, code}, 1'b0, 1'b1, 32'h1);
    check(instr, code);
  endtask

  // Dummy path shifts out the value left by the previous scan first
  task automatic scan_dr(input logic [5:0] len, input logic [31:0] d,
                         input logic sel);
    logic [31:0] m;
    m = (len == 6'h20) ? 32'hFFFFFFFF : (32'h1 << len) - 32'h1;
    do_cmd(1'b0, len, d & m, 1'b0, 1'b1,
           ((d << 1) | {31'h0, sel & prev}) & m);
    if (sel)
      prev = d[len - 1];
    check(dummy, prev);
  endtask

  task automatic lines(input logic [1:0] dp, input logic [1:0] hp,
                       input logic [1:0] lvl);
    @(negedge mclk);
    {dev_pull, host_pull} = {dp, hp};
    for (int n = 0; n < 200 && (dev_lvl !== lvl || host_lvl !== lvl); n++)
      @(negedge mclk);
    check(dev_lvl, lvl);
    check(host_lvl, lvl);
    check(link.emu_line, lvl);
  endtask

  task automatic bstep(input logic tms, input logic tdi);
    bad_if.tms = tms;
    bad_if.tdi = tdi;
    #40;
    tdo_cap = {bad_if.tdo_line, tdo_cap[7:1]};
    bad_if.tck = 1'b1;
    #40;
    bad_if.tck = 1'b0;
  endtask

  task automatic bseq(input logic [7:0] t, input int n);
    for (int k = 0; k < n; k++)
      bstep(t[k], 1'b0);
  endtask

  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
      check(rsp_err, e[32]);
      if (e[33])
        check(rsp_data, e[31:0]);
    end
  end

  initial begin
    #2000000;
    err_count++;
    $display("test watchdog expired");
    print_verdict();
  end

  initial begin
    rst_in = 1'b1;
    {cmd_valid, cmd_ir, cmd_len, cmd_data} = '0;
    {dev_pull, host_pull, prev} = '0;
    {bad_if.tck, bad_if.tms, bad_if.tdi, bad_if.trst_n} = 4'h0;
    bad_if.host_emu_o = 2'h0;
    bad_if.host_emu_oe_n = 2'h3;
    void'($urandom(45733));
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst_in = 1'b0;
    wait_ready();
    check(instr, 8'hFF);
    check({dummy, priv, dev_lvl}, 4'h3);
    $display("test reset done");
    foreach (codes[k]) begin
      load_ir(codes[k]);
      scan_dr(6'h01, 32'h1, codes[k] != 8'hFF);
      scan_dr(6'h20, $urandom(), codes[k] != 8'hFF);
      scan_dr(6'($urandom_range(1, 32)), $urandom(), codes[k] != 8'hFF);
      check({priv, dev_lvl}, 3'h3);
    end
    $display("test loopback done");
    repeat (3) begin
      load_ir(8'h40 + 8'($urandom_range(0, 190)));
      scan_dr(6'($urandom_range(1, 32)), $urandom(), 1'b0);
      check(priv, 1'b0);
    end
    $display("test unlisted codes done");
    load_ir(8'hFF);
    for (int i = 0; i < 11; i++) begin
      do_cmd(1'b1, 6'h08, (i == 0) ? 32'h3 : 32'h1F + i, 1'b1, 1'b0, 0);
      check(instr, 8'hFF);
    end
    do_cmd(1'b0, 6'h00, 32'h5, 1'b1, 1'b0, 32'h0);
    do_cmd(1'b0, 6'h21, 32'h5, 1'b1, 1'b0, 32'h0);
    $display("test refusal done");
    lines(2'b01, 2'b00, 2'b10);
    lines(2'b00, 2'b10, 2'b01);
    lines(2'b01, 2'b10, 2'b00);
    lines(2'b00, 2'b00, 2'b11);
    $display("test emulation lines done");
    bad_if.trst_n = 1'b1;
    bseq(8'h1F, 5);
    bseq(8'h06, 5);
    for (int k = 0; k < 8; k++)
      bstep(k == 7, bad_code[k]);
    check(tdo_cap, 8'h01);
    bseq(8'h05, 5);
    check(b_instr, 8'h25);
    check(b_priv, 1'b1);
    bstep(1'b0, 1'b1);
    bstep(1'b1, 1'b1);
    check(tdo_cap[7:6], 2'b10);
    bseq(8'h01, 2);
    check(bad_if.tdo_line, 1'b1);
    $display("test fault side done");
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule
